// ---- hw/dpm_dual_port_mux.sv ----
`timescale 1ns/1ps
// Summary of operation
// [RL1] direction register always drives output enable
// [RL2] each bit: select, dir, out, in, ie, flag, edge
// [RL3] port1 bit0: drive low, pin clocks timer
// [RL4] port1 bits1-3: compares out, capture A in
// [RL5] port1 bit4: subsystem clock out, input unused
// [RL6] port1 bits5-7: compares 0-2 out, input unused
// [RL7] port2 bit0: auxiliary clock out, input unused
// [RL8] port2 bit1: drive low, pin is alt clock
// [RL9] port2 bits2-3: compares out, capture B in
// [RL10] port2 bit4: compare 2 out, input unused
// [RL11] port2 bits6-7: no pin, software-only flags
// [RL12] software may use those flags as soft interrupts
// [RL13] select clear: pin driven from output register
// [RL14] flag on chosen edge, irq gated by enable
module dpm_dual_port_mux
(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // register port
  input  wire dpm_pkg::dpm_bus_t     bus,
  output logic                 [7:0] rdata,
  // pins
  input  wire logic            [7:0] p1PinIn,
  output logic                 [7:0] p1PinOut,
  output logic                 [7:0] p1PinOe,
  input  wire logic            [5:0] p2PinIn,
  output logic                 [5:0] p2PinOut,
  output logic                 [5:0] p2PinOe,
  // on-chip peripherals
  input  wire dpm_pkg::dpm_periph_t  periph,
  output dpm_pkg::dpm_timer_in_t     timerIn,
  // interrupt requests
  output logic                       p1Irq,
  output logic                       p2Irq
);

  logic [7:0] p1Out_r;
  logic [7:0] p1Dir_r;
  logic [7:0] p1Ies_r;
  logic [7:0] p1Ie_r;
  logic [7:0] p1Sel_r;
  logic [7:0] p2Out_r;
  logic [7:0] p2Dir_r;
  logic [7:0] p2Ies_r;
  logic [7:0] p2Ie_r;
  logic [7:0] p2Sel_r;
  logic [7:0] p1Sync;
  logic [7:0] p2Sync;
  logic [7:0] p1Flag;
  logic [7:0] p2Flag;
  logic [7:0] p1Mod;
  logic [7:0] p2Mod;
  logic [7:0] p1Drv_nxt;
  logic [7:0] p2Drv_nxt;
  logic [7:0] rdata_nxt;
  logic       p1FlagWr;
  logic       p2FlagWr;

  function automatic logic [7:0] mux_bits(input logic [7:0] sel,
                                          input logic [7:0] mod,
                                          input logic [7:0] gp);
    mux_bits = (sel & mod) | (~sel & gp);
  endfunction

  function automatic logic is_wr(input dpm_pkg::dpm_bus_t b, input logic [3:0] a);
    is_wr = b.wr && (b.addr == a);
  endfunction

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  dpm_sync u_sync1
  (
    .ref_clk (ref_clk),
    .d       (p1PinIn),
    .q       (p1Sync)
  );

  dpm_sync u_sync2
  (
    .ref_clk (ref_clk),
    .d       ({2'b00, p2PinIn}), // [RL11]
    .q       (p2Sync)
  );

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      p1Out_r <= dpm_pkg::REG_RST;
      p1Dir_r <= dpm_pkg::REG_RST;
      p1Ies_r <= dpm_pkg::REG_RST;
      p1Ie_r  <= dpm_pkg::REG_RST;
      p1Sel_r <= dpm_pkg::REG_RST;
    end
    else
    begin
      if (is_wr(bus, dpm_pkg::ADDR_P1_OUT)) p1Out_r <= bus.wdata; // [RL2]
      if (is_wr(bus, dpm_pkg::ADDR_P1_DIR)) p1Dir_r <= bus.wdata;
      if (is_wr(bus, dpm_pkg::ADDR_P1_IES)) p1Ies_r <= bus.wdata;
      if (is_wr(bus, dpm_pkg::ADDR_P1_IE))  p1Ie_r  <= bus.wdata;
      if (is_wr(bus, dpm_pkg::ADDR_P1_SEL)) p1Sel_r <= bus.wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      p2Out_r <= dpm_pkg::REG_RST;
      p2Dir_r <= dpm_pkg::REG_RST;
      p2Ies_r <= dpm_pkg::REG_RST;
      p2Ie_r  <= dpm_pkg::REG_RST;
      p2Sel_r <= dpm_pkg::REG_RST;
    end
    else
    begin
      if (is_wr(bus, dpm_pkg::ADDR_P2_OUT)) p2Out_r <= bus.wdata; // [RL2]
      if (is_wr(bus, dpm_pkg::ADDR_P2_DIR)) p2Dir_r <= bus.wdata;
      if (is_wr(bus, dpm_pkg::ADDR_P2_IES)) p2Ies_r <= bus.wdata;
      if (is_wr(bus, dpm_pkg::ADDR_P2_IE))  p2Ie_r  <= bus.wdata;
      if (is_wr(bus, dpm_pkg::ADDR_P2_SEL)) p2Sel_r <= bus.wdata;
    end
  end

  // ----------------------------------------
  // interrupt flags
  // ----------------------------------------
  assign p1FlagWr = is_wr(bus, dpm_pkg::ADDR_P1_IFG);
  assign p2FlagWr = is_wr(bus, dpm_pkg::ADDR_P2_IFG);

  dpm_port u_flag1
  (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .pinSync   (p1Sync),
    .edgeSel   (p1Ies_r),
    .pinMask   (8'hFF),
    .flagWr    (p1FlagWr),
    .flagWdata (bus.wdata),
    .flag      (p1Flag)
  );

  dpm_port u_flag2
  (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .pinSync   (p2Sync),
    .edgeSel   (p2Ies_r),
    .pinMask   (dpm_pkg::P2_PIN_MASK), // [RL11]
    .flagWr    (p2FlagWr),
    .flagWdata (bus.wdata),
    .flag      (p2Flag)
  );

  // ----------------------------------------
  // module output selection
  // ----------------------------------------
  always_comb
  begin
    p1Mod    = 8'h00;
    p1Mod[0] = 1'b0;                    // [RL3]
    p1Mod[1] = periph.cmp0;             // [RL4]
    p1Mod[2] = periph.cmp1;             // [RL4]
    p1Mod[3] = periph.cmp2;             // [RL4]
    p1Mod[4] = periph.subsysClk;        // [RL5]
    p1Mod[5] = periph.cmp0;             // [RL6]
    p1Mod[6] = periph.cmp1;             // [RL6]
    p1Mod[7] = periph.cmp2;             // [RL6]
    p2Mod    = 8'h00;
    p2Mod[0] = periph.auxClk;           // [RL7]
    p2Mod[1] = 1'b0;                    // [RL8]
    p2Mod[2] = periph.cmp0;             // [RL9]
    p2Mod[3] = periph.cmp1;             // [RL9]
    p2Mod[4] = periph.cmp2;             // [RL10]
    // bit 5 special function not carried here: held low
    p2Mod[5] = 1'b0;
    p2Mod[6] = 1'b0;                    // [RL11]
    p2Mod[7] = 1'b0;                    // [RL11]
    p1Drv_nxt = mux_bits(p1Sel_r, p1Mod, p1Out_r); // [RL13]
    p2Drv_nxt = mux_bits(p2Sel_r, p2Mod, p2Out_r); // [RL13]
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      p1PinOut <= 8'h00;
      p1PinOe  <= 8'h00;
    end
    else
    begin
      p1PinOut <= p1Drv_nxt;                     // [RL13]
      p1PinOe  <= p1Dir_r;                       // [RL1]
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      p2PinOut <= 6'h00;
      p2PinOe  <= 6'h00;
    end
    else
    begin
      p2PinOut <= p2Drv_nxt[dpm_pkg::P2_PINS-1:0]; // [RL13]
      p2PinOe  <= p2Dir_r[dpm_pkg::P2_PINS-1:0];   // [RL1]
    end
  end

  // ----------------------------------------
  // timer inputs, gated by select
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      timerIn.timerExtClockIn <= 1'b0;
      timerIn.timerAltClockIn <= 1'b0;
      timerIn.capture0InputA  <= 1'b0;
      timerIn.capture1InputA  <= 1'b0;
      timerIn.capture2InputA  <= 1'b0;
      timerIn.capture0InputB  <= 1'b0;
      timerIn.capture1InputB  <= 1'b0;
    end
    else
    begin
      timerIn.timerExtClockIn <= p1Sel_r[0] & p1Sync[0]; // [RL3]
      timerIn.capture0InputA  <= p1Sel_r[1] & p1Sync[1]; // [RL4]
      timerIn.capture1InputA  <= p1Sel_r[2] & p1Sync[2]; // [RL4]
      timerIn.capture2InputA  <= p1Sel_r[3] & p1Sync[3]; // [RL4]
      timerIn.timerAltClockIn <= p2Sel_r[1] & p2Sync[1]; // [RL8]
      timerIn.capture0InputB  <= p2Sel_r[2] & p2Sync[2]; // [RL9]
      timerIn.capture1InputB  <= p2Sel_r[3] & p2Sync[3]; // [RL9]
    end
  end

  // ----------------------------------------
  // interrupt requests
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      p1Irq <= 1'b0;
    else
      p1Irq <= |(p1Flag & p1Ie_r); // [RL14]
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      p2Irq <= 1'b0;
    else
      p2Irq <= |(p2Flag & p2Ie_r); // [RL14]
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb
  begin
    rdata_nxt = 8'h00;
    unique case (bus.addr)
      dpm_pkg::ADDR_P1_IN:  rdata_nxt = p1Sync; // [RL2]
      dpm_pkg::ADDR_P1_OUT: rdata_nxt = p1Out_r;
      dpm_pkg::ADDR_P1_DIR: rdata_nxt = p1Dir_r;
      dpm_pkg::ADDR_P1_IFG: rdata_nxt = p1Flag;
      dpm_pkg::ADDR_P1_IES: rdata_nxt = p1Ies_r;
      dpm_pkg::ADDR_P1_IE:  rdata_nxt = p1Ie_r;
      dpm_pkg::ADDR_P1_SEL: rdata_nxt = p1Sel_r;
      dpm_pkg::ADDR_P2_IN:  rdata_nxt = p2Sync;
      dpm_pkg::ADDR_P2_OUT: rdata_nxt = p2Out_r;
      dpm_pkg::ADDR_P2_DIR: rdata_nxt = p2Dir_r;
      dpm_pkg::ADDR_P2_IFG: rdata_nxt = p2Flag;
      dpm_pkg::ADDR_P2_IES: rdata_nxt = p2Ies_r;
      dpm_pkg::ADDR_P2_IE:  rdata_nxt = p2Ie_r;
      dpm_pkg::ADDR_P2_SEL: rdata_nxt = p2Sel_r;
      default:              rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (bus.rd)
      rdata <= rdata_nxt;
    else
      rdata <= 8'h00;
  end

endmodule

// ---- hw/dpm_pkg.sv ----
package dpm_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [3:0] ADDR_P1_IN  = 4'h0;
  localparam logic [3:0] ADDR_P1_OUT = 4'h1;
  localparam logic [3:0] ADDR_P1_DIR = 4'h2;
  localparam logic [3:0] ADDR_P1_IFG = 4'h3;
  localparam logic [3:0] ADDR_P1_IES = 4'h4;
  localparam logic [3:0] ADDR_P1_IE  = 4'h5;
  localparam logic [3:0] ADDR_P1_SEL = 4'h6;
  localparam logic [3:0] ADDR_P2_IN  = 4'h8;
  localparam logic [3:0] ADDR_P2_OUT = 4'h9;
  localparam logic [3:0] ADDR_P2_DIR = 4'hA;
  localparam logic [3:0] ADDR_P2_IFG = 4'hB;
  localparam logic [3:0] ADDR_P2_IES = 4'hC;
  localparam logic [3:0] ADDR_P2_IE  = 4'hD;
  localparam logic [3:0] ADDR_P2_SEL = 4'hE;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int          PORT_W      = 8;
  localparam int          P2_PINS     = 6;
  localparam logic [7:0]  REG_RST     = 8'h00;
  localparam logic [7:0]  P2_PIN_MASK = 8'h3F;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dpm_bus_t;

  typedef struct packed {
    logic cmp0;
    logic cmp1;
    logic cmp2;
    logic subsysClk;
    logic auxClk;
  } dpm_periph_t;

  typedef struct packed {
    logic timerExtClockIn;
    logic timerAltClockIn;
    logic capture0InputA;
    logic capture1InputA;
    logic capture2InputA;
    logic capture0InputB;
    logic capture1InputB;
  } dpm_timer_in_t;

endpackage

// ---- hw/dpm_port.sv ----
`timescale 1ns/1ps
module dpm_port
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // synchronised pin levels and edge controls
  input  wire logic [7:0] pinSync,
  input  wire logic [7:0] edgeSel,
  input  wire logic [7:0] pinMask,
  // software flag access
  input  wire logic       flagWr,
  input  wire logic [7:0] flagWdata,
  output logic      [7:0] flag
);

  logic [7:0] prev_r;
  logic [7:0] edgeHit;

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  // no reset: follows the pin level, so reset release gives no edge
  always_ff @(posedge ref_clk)
  begin
    prev_r <= pinSync;
  end

  // edge select low: rising, high: falling
  always_comb
  begin
    edgeHit = pinMask & ((~edgeSel & ~prev_r & pinSync) | (edgeSel & prev_r & ~pinSync)); // [RL14]
  end

  // ----------------------------------------
  // flags: hardware set wins over write
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      flag <= dpm_pkg::REG_RST;
    else if (flagWr)
      flag <= flagWdata | edgeHit; // [RL14]
    else
      flag <= flag | edgeHit;
  end

endmodule

// ---- hw/dpm_sync.sv ----
`timescale 1ns/1ps
module dpm_sync
(
  // clock
  input  wire logic       ref_clk,
  // data
  input  wire logic [7:0] d,
  output logic      [7:0] q
);

  logic [7:0] stage1_r;

  // ----------------------------------------
  // two-flop synchroniser, no reset
  // ----------------------------------------
  // tracks the pin through reset, so no false edge follows its release
  always_ff @(posedge ref_clk)
  begin
    stage1_r <= d;
    q        <= stage1_r;
  end

endmodule

// ---- verif/dpm_chk.sv ----
`timescale 1ns/1ps
module dpm_chk
(
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // watched ports
  input  wire dpm_pkg::dpm_bus_t      bus,
  input  wire logic [7:0]             rdata,
  input  wire logic [7:0]             p1PinIn,
  input  wire logic [7:0]             p1PinOe,
  input  wire logic [5:0]             p2PinIn,
  input  wire logic [5:0]             p2PinOe,
  input  wire dpm_pkg::dpm_timer_in_t timerIn,
  input  wire logic                   p1Irq,
  input  wire logic                   p2Irq
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence dirWr1;
    bus.wr && bus.addr == dpm_pkg::ADDR_P1_DIR;
  endsequence
  sequence dirWr2;
    bus.wr && bus.addr == dpm_pkg::ADDR_P2_DIR;
  endsequence
  p1_oe_dir_a: assert property (dirWr1 |-> ##2 p1PinOe == $past(bus.wdata, 2))
    else $error("port1 enable differs from direction");
  p2_oe_dir_a: assert property (dirWr2 |-> ##2 p2PinOe == $past(bus.wdata[5:0], 2))
    else $error("port2 enable differs from direction");
  rd_idle_a: assert property (!bus.rd |=> rdata == 8'h00)
    else $error("read data without read");
  unmapped_rd_a: assert property (bus.rd && bus.addr inside {4'h7, 4'hF} |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  rst_quiet_a: assert property ($fell(rst) |-> rdata == 8'h00 && p1PinOe == 8'h00 && !p1Irq && !p2Irq)
    else $error("outputs active after reset");
  ext_clk_a: assert property (timerIn.timerExtClockIn |-> $past(p1PinIn[0], 3))
    else $error("timer clock without pin");
  cap_a_a: assert property (timerIn.capture1InputA |-> $past(p1PinIn[2], 3))
    else $error("capture A without pin");
  alt_clk_a: assert property (timerIn.timerAltClockIn |-> $past(p2PinIn[1], 3))
    else $error("alternate clock without pin");
endmodule
bind dpm_dual_port_mux dpm_chk i_chk (.ref_clk, .rst, .bus, .rdata, .p1PinIn, .p1PinOe,
  .p2PinIn, .p2PinOe, .timerIn, .p1Irq, .p2Irq);

// ---- verif/dpm_far_model.sv ----
`timescale 1ns/1ps
module dpm_far_model
(
  // clock
  input  wire logic                 ref_clk,
  // outside sources set by the bench
  input  wire logic [7:0]           p1Ext,
  input  wire logic [5:0]           p2Ext,
  input  wire logic [4:0]           perSet,
  // device pin drive
  input  wire logic [7:0]           p1PinOut,
  input  wire logic [7:0]           p1PinOe,
  input  wire logic [5:0]           p2PinOut,
  input  wire logic [5:0]           p2PinOe,
  // resolved pins and on-chip sources
  output logic      [7:0]           p1PinIn,
  output logic      [5:0]           p2PinIn,
  output dpm_pkg::dpm_periph_t      periph
);
  // ----------------------------------------
  // wire level: a driven bit follows the device
  // ----------------------------------------
  assign p1PinIn = (p1PinOe & p1PinOut) | (~p1PinOe & p1Ext);
  assign p2PinIn = (p2PinOe & p2PinOut) | (~p2PinOe & p2Ext);
  assign periph  = dpm_pkg::dpm_periph_t'(perSet);
endmodule

// ---- verif/test_dpm_dual_port_mux.sv ----
`timescale 1ns/1ps
module test_dpm_dual_port_mux;
  logic                   ref_clk;
  logic                   rst;
  dpm_pkg::dpm_bus_t      bus;
  logic [7:0]             rdata, p1PinIn, p1PinOut, p1PinOe, p1Ext;
  logic [5:0]             p2PinIn, p2PinOut, p2PinOe, p2Ext;
  logic [4:0]             perSet;
  dpm_pkg::dpm_periph_t   periph;
  dpm_pkg::dpm_timer_in_t timerIn;
  logic                   p1Irq, p2Irq;
  int                     n_mismatch = 0;
  int                     n_tests = 0;
  logic [7:0]             p1Tab [7] = '{8'h01, 8'h00, 8'h02, 8'h04, 8'h08, 8'h00, 8'h00};
  logic [5:0]             p2Tab [7] = '{6'h00, 6'h02, 6'h00, 6'h00, 6'h00, 6'h04, 6'h08};

  dpm_dual_port_mux i_dut (.ref_clk, .rst, .bus, .rdata, .p1PinIn, .p1PinOut, .p1PinOe,
    .p2PinIn, .p2PinOut, .p2PinOe, .periph, .timerIn, .p1Irq, .p2Irq);
  dpm_far_model i_far (.ref_clk, .p1Ext, .p2Ext, .perSet, .p1PinOut, .p1PinOe,
    .p2PinOut, .p2PinOe, .p1PinIn, .p2PinIn, .periph);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      n_mismatch++;
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task setp(input logic [7:0] a, input logic [5:0] b);
    @(posedge ref_clk);
    p1Ext <= a;
    p2Ext <= b;
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1;
    chk("read data", e, rdata);
  endtask

  task print_verdict;
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    for (int i = 0; i < 16; i++)
      rd(4'(i), 8'h00);
    for (int i = 1; i < 15; i++)
      if (i % 8 != 0 && i != 7)
      begin
        wr(4'(i), 8'h5A);
        rd(4'(i), 8'h5A);
        wr(4'(i), 8'h00);
      end
    wr(4'h7, 8'hFF);
    rd(4'h7, 8'h00);
    wr(dpm_pkg::ADDR_P1_IN, 8'hFF);
    rd(dpm_pkg::ADDR_P1_IN, 8'h00);
  endtask

  task t_drive;
    wr(dpm_pkg::ADDR_P1_DIR, 8'hFF);
    wr(dpm_pkg::ADDR_P2_DIR, 8'hFF);
    wr(dpm_pkg::ADDR_P1_OUT, 8'hA5);
    wr(dpm_pkg::ADDR_P2_OUT, 8'h3C);
    tick(2);
    chk("p1 out", 8'hA5, p1PinOut);
    chk("p2 out", 8'h3C, {2'b00, p2PinOut});
    wr(dpm_pkg::ADDR_P1_SEL, 8'hFF);
    wr(dpm_pkg::ADDR_P2_SEL, 8'hFF);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge ref_clk);
      perSet <= (k == 0) ? 5'b10110 : 5'b01101;
      tick(3);
      chk("p1 oe", 8'hFF, p1PinOe);
      chk("p2 oe", 8'h3F, {2'b00, p2PinOe});
      chk("p1 mod", {periph.cmp2, periph.cmp1, periph.cmp0, periph.subsysClk, periph.cmp2,
        periph.cmp1, periph.cmp0, 1'b0}, p1PinOut);
      chk("p2 mod", {3'b000, periph.cmp2, periph.cmp1, periph.cmp0, 1'b0, periph.auxClk},
        {2'b00, p2PinOut});
    end
    wr(dpm_pkg::ADDR_P1_DIR, 8'h00);
    wr(dpm_pkg::ADDR_P2_DIR, 8'h00);
    tick(2);
    chk("p1 oe", 8'h00, p1PinOe);
  endtask

  task t_capture;
    for (int j = 0; j < 7; j++)
    begin
      setp(p1Tab[j], p2Tab[j]);
      tick(4);
      chk("timer in", 8'(7'h40 >> j), {1'b0, timerIn});
    end
    setp(8'hF0, 6'h31);
    tick(4);
    chk("timer in", 8'h00, {1'b0, timerIn});
    setp(8'hFF, 6'h3F);
    wr(dpm_pkg::ADDR_P1_SEL, 8'h00);
    wr(dpm_pkg::ADDR_P2_SEL, 8'h00);
    tick(4);
    chk("timer in", 8'h00, {1'b0, timerIn});
    setp(8'h00, 6'h00);
  endtask

  task t_irq;
    wr(dpm_pkg::ADDR_P1_IFG, 8'h00);
    wr(dpm_pkg::ADDR_P1_IE, 8'hFF);
    setp(8'h04, 6'h00);
    tick(5);
    rd(dpm_pkg::ADDR_P1_IFG, 8'h04);
    chk("p1 irq", 8'h01, {7'h00, p1Irq});
    wr(dpm_pkg::ADDR_P1_IFG, 8'h00);
    wr(dpm_pkg::ADDR_P1_IES, 8'h04);
    setp(8'h00, 6'h00);
    tick(5);
    rd(dpm_pkg::ADDR_P1_IFG, 8'h04);
    wr(dpm_pkg::ADDR_P1_IE, 8'h00);
    tick(2);
    chk("p1 irq", 8'h00, {7'h00, p1Irq});
    wr(dpm_pkg::ADDR_P2_IE, 8'hC0);
    wr(dpm_pkg::ADDR_P2_IFG, 8'hC0);
    tick(2);
    chk("p2 irq", 8'h01, {7'h00, p2Irq});
    rd(dpm_pkg::ADDR_P2_IFG, 8'hC0);
    wr(dpm_pkg::ADDR_P2_IFG, 8'h00);
    tick(2);
    chk("p2 irq", 8'h00, {7'h00, p2Irq});
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    bus = '0;
    p1Ext = 8'h00;
    p2Ext = 6'h00;
    perSet = 5'b00000;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_drive;
    t_capture;
    t_irq;
    print_verdict;
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    print_verdict;
  end
endmodule
